// ### adc_host_port.sv
// Purpose: host end: frames transfers and buffers returned words
// Assumes: one clock; the serial clock is made here by a divider
// Notes:   every transfer is framed by chip select and waits for end of conversion
`include "adc_link_defines.svh"
`default_nettype none
module adc_word_fifo #(
  parameter int WIDTH = `WORD_BITS,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clock_in,   // system clock
  input  wire logic             nrst_in,    // async reset, active low
  input  wire logic             push_valid_in,   // write request
  output logic                  push_ready_out,  // room for a word
  input  wire logic [WIDTH-1:0] push_data_in,    // word written
  output logic                  pop_valid_out,   // word available
  input  wire logic             pop_ready_in,    // reader takes word
  output logic [WIDTH-1:0]      pop_data_out     // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             do_wr;
  logic             do_rd;

  assign push_ready_out = cnt_reg != (AW+1)'(DEPTH);
  assign pop_valid_out  = cnt_reg != '0;
  assign do_wr          = push_valid_in && push_ready_out;
  assign do_rd          = pop_valid_out && pop_ready_in;
  assign pop_data_out   = mem[rd_reg];

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem[wr_reg] <= push_data_in;
    end
  end

  // pointers wrap because depth is a power of two
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= do_wr ? wr_reg + AW'(1) : wr_reg;
      rd_reg  <= do_rd ? rd_reg + AW'(1) : rd_reg;
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

module adc_host_port (
  input  wire logic                  clock_in,        // 20 MHz system clock
  input  wire logic                  nrst_in,         // async reset, active low
  adc_link_if.host_mp                link,            // pins toward the converter
  input  wire logic                  req_valid_in,    // transfer request
  output logic                       req_ready_out,   // request taken this cycle
  input  wire logic [`SEL_BITS-1:0]  req_select_in,   // select for next conversion
  input  wire logic                  req_long_in,     // 16 clocks instead of 10
  input  wire logic                  req_split_in,    // 16 clocks as two bursts of 8
  output logic                       word_valid_out,  // returned word available
  input  wire logic                  word_ready_in,   // reader takes the word
  output logic [`WORD_BITS-1:0]      word_data_out    // returned word, result on top
);
  adc_link_pkg::host_state_t r;
  adc_link_pkg::host_state_t n;
  logic                      fifo_ready;
  logic                      timer_done;
  logic [`SEL_BITS-1:0]      safe_sel;
  logic [4:0]                next_edges;
  logic [`WORD_BITS-1:0]     rx_shift;

  adc_word_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_DEPTH)) adc_word_fifo_i (
    .clock_in       (clock_in),
    .nrst_in        (nrst_in),
    .push_valid_in  (r.push),
    .push_ready_out (fifo_ready),
    .push_data_in   (r.word),
    .pop_valid_out  (word_valid_out),
    .pop_ready_in   (word_ready_in),
    .pop_data_out   (word_data_out)
  );

  // forbidden selects never reach the pins; they become the zero test
  assign safe_sel = (req_select_in <= `SEL_LAST_CHAN ||
                    (req_select_in >= `SEL_HALF && req_select_in <= `SEL_FULL)) ?
                    req_select_in : `SEL_ZERO;
  // a full buffer holds off new transfers, so no word is ever dropped
  assign req_ready_out = r.state == adc_link_pkg::H_IDLE && r.eoc_lvl && fifo_ready;
  assign timer_done    = r.timer == `SCLK_HALF_LAST;
  assign next_edges    = r.edges + 5'h01;
  assign rx_shift      = {r.rx[`WORD_BITS-2:0], r.do_s[2]};

  // next-state logic for the host
  always_comb begin
    n         = r;
    n.push    = 1'b0;
    n.eoc_s   = {r.eoc_s[1:0], link.eoc};
    n.do_s    = {r.do_s[1:0], link.dout_line};
    if (r.eoc_s[1] == r.eoc_s[2]) begin
      n.eoc_lvl = r.eoc_s[2];
    end
    if (!r.eoc_lvl && r.state != adc_link_pkg::H_IDLE) begin
      n.seen_low = 1'b1;
    end
    if (r.state != adc_link_pkg::H_IDLE && r.state != adc_link_pkg::H_WAIT) begin
      n.timer = r.timer + 8'h01;
    end
    unique case (r.state)
      adc_link_pkg::H_IDLE: begin
        if (req_valid_in && req_ready_out) begin
          n.tx       = {safe_sel, `SEL_PAD};
          n.total    = req_long_in ? `LONG_EDGES : `SHORT_EDGES;
          n.split    = req_long_in && req_split_in;
          n.cs_n     = 1'b0;
          n.timer    = '0;
          n.edges    = '0;
          n.rx       = '0;
          n.seen_low = 1'b0;
          n.state    = adc_link_pkg::H_LEAD;
        end
      end
      adc_link_pkg::H_LEAD, adc_link_pkg::H_LOW: begin
        // raise the clock; no sample here, the device bit is still in flight
        if (timer_done) begin
          n.timer = '0;
          n.sclk  = 1'b1;
          n.state = adc_link_pkg::H_HIGH;
        end
      end
      adc_link_pkg::H_HIGH: begin
        // sample just before the fall: filter and shift lag take about seven cycles
        if (timer_done) begin
          n.timer = '0;
          n.sclk  = 1'b0;
          n.rx    = rx_shift;
          n.edges = next_edges;
          n.tx    = {r.tx[`WORD_BITS-2:0], 1'b0};
          if (next_edges == r.total) begin
            n.cs_n  = 1'b1;
            n.push  = 1'b1;
            n.word  = (r.total == `LONG_EDGES) ? rx_shift :
                      {rx_shift[`RES_BITS-1:0], `RES_PAD};
            n.state = adc_link_pkg::H_WAIT;
          end else if (r.split && next_edges == `BURST_EDGES) begin
            n.state = adc_link_pkg::H_PAUSE;
          end else begin
            n.state = adc_link_pkg::H_LOW;
          end
        end
      end
      adc_link_pkg::H_PAUSE: begin
        if (r.timer == `PAUSE_LAST) begin
          n.timer = '0;
          n.state = adc_link_pkg::H_LOW;
        end
      end
      adc_link_pkg::H_WAIT: begin
        // wait for a whole low-then-high swing of end of conversion
        if (r.seen_low && r.eoc_lvl) begin
          n.state = adc_link_pkg::H_IDLE;
        end
      end
      default: begin
        n.state = adc_link_pkg::H_IDLE;
      end
    endcase
  end

  // single state register
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r         <= '0;
      r.state   <= adc_link_pkg::H_IDLE;
      r.cs_n    <= 1'b1;
      r.eoc_s   <= 3'b111;
      r.eoc_lvl <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.din  = r.tx[`WORD_BITS-1];
endmodule
`default_nettype wire

// ### adc_link_defines.svh
// Purpose: named constants shared by both ends of the converter link
// Assumes: 20 MHz system clock on both ends
// Notes:   counts are sized to the registers they meet
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH
`define SEL_BITS      4
`define RES_BITS      10
`define LEVEL_BITS    12
`define WORD_BITS     16
`define SEL_PAD       12'h000
`define RES_PAD       6'h00
`define ADDR_EDGES    5'h04
`define SHORT_EDGES   5'h0a
`define BURST_EDGES   5'h08
`define EXT_RISE      5'h0b
`define LONG_EDGES    5'h10
`define SEL_LAST_CHAN 4'h4
`define SEL_HALF      4'hb
`define SEL_ZERO      4'hc
`define SEL_FULL      4'hd
`define CODE_HALF     10'h200
`define CODE_ZERO     10'h000
`define CODE_FULL     10'h3ff
`define SAR_TOP       10'h200
`define OSC_LAST      4'h7
`define CLK_PERIOD_NS  50
`define SCLK_PERIOD_NS 400
`define SCLK_HALF_LAST 8'((`SCLK_PERIOD_NS / `CLK_PERIOD_NS) / 2 - 1)
`define PAUSE_LAST    8'h3f
`define FIFO_DEPTH    16
`endif

// ### adc_link_if.sv
// Purpose: pins between the converter port and its host
// Assumes: host makes the serial clock and chip select
// Notes:   a released data-out line reads inverted, so a badly timed sample shows
`default_nettype none
interface adc_link_if;
  logic sclk;       // serial clock from host
  logic cs_n;       // chip select, active low
  logic din;        // select bits to device
  logic dout_drv;   // device data-out value
  logic dout_oe_n;  // device drives data-out while low
  logic eoc;        // end of conversion, high when result ready
  wire  dout_line;  // data-out as the host sees it

  // no pull resistor here: a released line shows the inverse, so a sample taken
  // before the device drives can never pass by luck
  assign dout_line = dout_oe_n ? ~dout_drv : dout_drv;

  modport device_mp (input sclk, input cs_n, input din, output dout_drv, output dout_oe_n, output eoc);
  modport host_mp (output sclk, output cs_n, output din, input dout_line, input eoc);
endinterface
`default_nettype wire

// ### adc_link_pkg.sv
// Purpose: state types of both link ends
// Assumes: constants come from adc_link_defines.svh
// Notes:   each link-end module keeps all its own state in one struct
`include "adc_link_defines.svh"
`default_nettype none
package adc_link_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL} dev_phase_t;
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_PAUSE, H_WAIT} host_phase_t;

  typedef struct packed {
    dev_phase_t                 state;
    logic [2:0]                 ck_s;
    logic [2:0]                 cs_s;
    logic [2:0]                 di_s;
    logic                       ck_lvl;
    logic                       cs_lvl;
    logic [`SEL_BITS-1:0]       addr;
    logic [`RES_BITS-1:0]       sr;
    logic [4:0]                 rise_cnt;
    logic [4:0]                 fall_cnt;
    logic                       conv_busy;
    logic [3:0]                 osc_cnt;
    logic [`RES_BITS-1:0]       mask;
    logic [`RES_BITS-1:0]       sar;
    logic [`RES_BITS-1:0]       target;
    logic [`RES_BITS-1:0]       result;
    logic                       eoc;
    logic                       done_p;
  } dev_state_t;

  typedef struct packed {
    host_phase_t                state;
    logic [7:0]                 timer;
    logic [4:0]                 edges;
    logic [4:0]                 total;
    logic                       split;
    logic [`WORD_BITS-1:0]      tx;
    logic [`WORD_BITS-1:0]      rx;
    logic                       sclk;
    logic                       cs_n;
    logic [2:0]                 eoc_s;
    logic [2:0]                 do_s;
    logic                       eoc_lvl;
    logic                       seen_low;
    logic                       push;
    logic [`WORD_BITS-1:0]      word;
  } host_state_t;
endpackage
`default_nettype wire

// ### adc_link_props.sv
// Purpose: timing checks on the link pins between host end and converter end
// Assumes: one 20 MHz domain; pins are sampled on its rising edge
// Notes:   the fall counter survives the frame so tail checks still see it
`default_nettype none
module adc_link_props (
  input wire logic clock_in,  // system clock
  input wire logic nrst_in,   // async reset, active low
  input wire logic sclk,      // serial clock
  input wire logic cs_n,      // chip select
  input wire logic din,       // select bits
  input wire logic dout_drv,  // device data value
  input wire logic dout_oe_n, // device drive enable, low drives
  input wire logic eoc        // end of conversion
);
  logic       sclk_q;
  logic       cs_q;
  logic [4:0] fcnt;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  // falls since the frame opened; cleared only by a new select fall
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      fcnt   <= 5'h00;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      if (cs_q && !cs_n) begin
        fcnt <= 5'h00;
      end else if (sclk_q && !sclk) begin
        fcnt <= fcnt + 5'h01;
      end
    end
  end

  a_float_idle: assert property (
    cs_n [*6] |-> dout_oe_n) else $error("data out driven while deselected");
  a_drive_on_select: assert property (
    $fell(cs_n) |-> ##[2:6] !dout_oe_n) else $error("data out not driven after select");
  a_tail_low: assert property (
    (fcnt > 5'h0a) && !dout_oe_n |-> !dout_drv) else $error("data out not low after tenth fall");
  a_eoc_tenth_fall: assert property (
    $fell(eoc) |-> fcnt == 5'h0a) else $error("eoc fell away from tenth fall");
  a_eoc_rise_window: assert property (
    $fell(eoc) |-> ##[70:110] $rose(eoc)) else $error("eoc did not rise after conversion time");
  a_din_stable_rise: assert property (
    $rose(sclk) |-> $stable(din)) else $error("select bit moved at a rising clock");
  a_half_period: assert property (
    $rose(sclk) |=> sclk [*3] ##1 !sclk) else $error("serial clock high time wrong");
  a_clock_in_frame: assert property (
    $changed(sclk) |-> !$past(cs_n)) else $error("serial clock moved outside a frame");
  a_start_after_eoc: assert property (
    $fell(cs_n) |-> eoc) else $error("frame opened during conversion");
endmodule
`default_nettype wire

// ### adc_serial_port.sv
// Purpose: device end: serial transfer and conversion sequencing
// Assumes: link pins are asynchronous and are sampled through three flops
// Notes:   analog inputs arrive as digital levels; the sar loop compares against them
`include "adc_link_defines.svh"
`default_nettype none
// Notes on behaviour
// - sixteen clocks as one burst or two
// - only top four input bits select
// - result in top ten bits, six zeros
// - codes 0..4 pick channels; B,C,D self-test; others forbidden
// - codes B,C,D convert half, zero, full
// - host gives 11th rise before conversion ends
// - shifted result is the previous conversion
// - received select drives the next conversion
// - end-of-conversion output marks a ready result
// - result saturates at both references
// - 10-clock, 11-16 framed, 16-clock held modes
// - select captured msb first, first four rises
// - data-out floats with cs high, shifts, then low
// - eoc falls at tenth fall, rises when done
// - after tenth edge oscillator runs the conversion
module adc_serial_port (
  input  wire logic                   clock_in,                // 20 MHz system clock
  input  wire logic                   nrst_in,                 // async reset, active low
  adc_link_if.device_mp               link,                    // pins toward the host
  input  wire logic [`LEVEL_BITS-1:0] analog_channel_zero_in,  // channel 0 level
  input  wire logic [`LEVEL_BITS-1:0] analog_channel_one_in,   // channel 1 level
  input  wire logic [`LEVEL_BITS-1:0] analog_channel_two_in,   // channel 2 level
  input  wire logic [`LEVEL_BITS-1:0] analog_channel_three_in, // channel 3 level
  input  wire logic [`LEVEL_BITS-1:0] analog_channel_four_in,  // channel 4 level
  input  wire logic [`LEVEL_BITS-1:0] lower_reference_in,      // level giving code zero
  input  wire logic [`LEVEL_BITS-1:0] upper_reference_in,      // level giving full scale
  output logic [`RES_BITS-1:0]        result_out,              // last finished result
  output logic                        result_valid_out,        // pulse when result updates
  output logic                        busy_out                 // conversion running
);
  adc_link_pkg::dev_state_t r;
  adc_link_pkg::dev_state_t n;
  logic                     ck_agree;
  logic                     cs_agree;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic                     cs_fall;
  logic                     start_xfer;
  logic [`RES_BITS-1:0]     sar_try;
  logic [`RES_BITS-1:0]     sel_target;

  // clamp a level into the code range between the references
  function automatic logic [`RES_BITS-1:0] clamp_level(input logic [`LEVEL_BITS-1:0] lvl,
                                                       input logic [`LEVEL_BITS-1:0] lo,
                                                       input logic [`LEVEL_BITS-1:0] hi);
    logic [`LEVEL_BITS-1:0] span;
    span = lvl - lo;
    if (lvl <= lo) begin
      clamp_level = `CODE_ZERO;
    end else if (lvl >= hi || span > `LEVEL_BITS'(`CODE_FULL)) begin
      clamp_level = `CODE_FULL;
    end else begin
      clamp_level = span[`RES_BITS-1:0];
    end
  endfunction

  // the self-test codes convert internal levels; forbidden codes read as zero
  always_comb begin
    unique case (r.addr)
      4'h0:      sel_target = clamp_level(analog_channel_zero_in, lower_reference_in, upper_reference_in);
      4'h1:      sel_target = clamp_level(analog_channel_one_in, lower_reference_in, upper_reference_in);
      4'h2:      sel_target = clamp_level(analog_channel_two_in, lower_reference_in, upper_reference_in);
      4'h3:      sel_target = clamp_level(analog_channel_three_in, lower_reference_in, upper_reference_in);
      `SEL_LAST_CHAN: sel_target = clamp_level(analog_channel_four_in, lower_reference_in,
                                               upper_reference_in);
      `SEL_HALF: sel_target = `CODE_HALF;
      `SEL_ZERO: sel_target = `CODE_ZERO;
      `SEL_FULL: sel_target = `CODE_FULL;
      default:   sel_target = `CODE_ZERO;
    endcase
  end

  // a pin change counts once the second and third flops agree
  // din skips that test: it is read only at a filtered rise, after
  // half a serial period of standing still
  assign ck_agree  = r.ck_s[1] == r.ck_s[2];
  assign cs_agree  = r.cs_s[1] == r.cs_s[2];
  assign sclk_rise = ck_agree && r.ck_s[2] && !r.ck_lvl;
  assign sclk_fall = ck_agree && !r.ck_s[2] && r.ck_lvl;
  assign cs_fall   = cs_agree && !r.cs_s[2] && r.cs_lvl;
  assign sar_try   = r.sar | r.mask;

  // next-state logic for the whole port
  always_comb begin
    n          = r;
    start_xfer = 1'b0;
    n.done_p   = 1'b0;
    n.ck_s     = {r.ck_s[1:0], link.sclk};
    n.cs_s     = {r.cs_s[1:0], link.cs_n};
    n.di_s     = {r.di_s[1:0], link.din};
    if (ck_agree) begin
      n.ck_lvl = r.ck_s[2];
    end
    if (cs_agree) begin
      n.cs_lvl = r.cs_s[2];
    end

    // successive approximation paced by the internal oscillator divider
    // eight system cycles per step, so a result lands 80 cycles after the tenth fall
    if (r.conv_busy) begin
      if (r.osc_cnt == `OSC_LAST) begin
        n.osc_cnt = '0;
        n.mask    = r.mask >> 1;
        if (sar_try <= r.target) begin
          n.sar = sar_try;
        end
        if (r.mask[0]) begin
          n.conv_busy = 1'b0;
          n.result    = (sar_try <= r.target) ? sar_try : r.sar;
          n.eoc       = 1'b1;
          n.done_p    = 1'b1;
        end
      end else begin
        n.osc_cnt = r.osc_cnt + 4'h1;
      end
    end

    unique case (r.state)
      adc_link_pkg::ST_IDLE: begin
        // only a filtered select fall opens a frame, so a short glitch does nothing
        if (cs_fall) begin
          start_xfer = 1'b1;
        end
      end
      adc_link_pkg::ST_SHIFT: begin
        if (r.cs_lvl) begin
          n.state = adc_link_pkg::ST_IDLE;                     // frame dropped early
        end else if (sclk_rise) begin
          n.rise_cnt = r.rise_cnt + 5'h01;
          if (r.rise_cnt < `ADDR_EDGES) begin
            n.addr = {r.addr[`SEL_BITS-2:0], r.di_s[2]};
          end
        end else if (sclk_fall) begin
          n.sr       = {r.sr[`RES_BITS-2:0], 1'b0};
          n.fall_cnt = r.fall_cnt + 5'h01;
          if (r.fall_cnt == `SHORT_EDGES - 5'h01) begin
            n.state     = adc_link_pkg::ST_TAIL;
            n.eoc       = 1'b0;
            n.conv_busy = 1'b1;
            n.osc_cnt   = '0;
            n.sar       = '0;
            n.mask      = `SAR_TOP;
            n.target    = sel_target;
          end
        end
      end
      adc_link_pkg::ST_TAIL: begin
        // a new select before the end aborts the running conversion
        if (cs_fall) begin
          start_xfer = 1'b1;
        end else if (r.cs_lvl) begin
          n.state = adc_link_pkg::ST_IDLE;                     // conversion keeps running
        end else begin
          // both counts stop at sixteen so a long held-low clock cannot wrap them
          if (sclk_rise && r.rise_cnt < `LONG_EDGES) begin
            n.rise_cnt = r.rise_cnt + 5'h01;
          end
          if (sclk_fall && r.fall_cnt < `LONG_EDGES) begin
            n.fall_cnt = r.fall_cnt + 5'h01;
          end
          // no 11th rise yet means a 10-clock stream; else wait for the 16th fall
          if (!r.conv_busy && (r.rise_cnt < `EXT_RISE || r.fall_cnt == `LONG_EDGES)) begin
            start_xfer = 1'b1;
          end
        end
      end
    endcase

    // a transfer always shifts out the result held before it began
    if (start_xfer) begin
      n.state     = adc_link_pkg::ST_SHIFT;
      n.sr        = n.result;
      n.rise_cnt  = '0;
      n.fall_cnt  = '0;
      n.conv_busy = 1'b0;
    end
  end

  // single state register; pins idle high for cs and low for the clock
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r           <= '0;
      r.state     <= adc_link_pkg::ST_IDLE;
      r.cs_s      <= 3'b111;
      r.di_s      <= 3'b000;
      r.cs_lvl    <= 1'b1;
      r.eoc       <= 1'b1;
      r.mask      <= `SAR_TOP;
    end else begin
      r <= n;
    end
  end

  // data-out floats while the select is seen high
  assign link.dout_drv  = r.sr[`RES_BITS-1];
  assign link.dout_oe_n = r.cs_lvl;
  assign link.eoc       = r.eoc;
  assign result_out       = r.result;
  assign result_valid_out = r.done_p;
  assign busy_out         = r.conv_busy;
endmodule
`default_nettype wire

// ### adc_serial_transfer_port_tb.sv
// Purpose: runs host end against converter end and checks returned words
// Assumes: host frames every transfer; words lag one conversion behind
// Notes:   the fifo is filled to refusal before any word is read
`include "adc_link_defines.svh"
`default_nettype none
module adc_serial_transfer_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_in;
  logic        nrst_in;
  logic        req_valid_in;
  logic        req_ready_out;
  logic [3:0]  req_select_in;
  logic        req_long_in;
  logic        req_split_in;
  logic        word_valid_out;
  logic        word_ready_in;
  logic [15:0] word_data_out;
  logic [9:0]  result_out;
  logic        result_valid_out;
  logic        busy_out;
  logic [11:0] lvl_tab [5] = '{12'h050, 12'h100, 12'h2a5, 12'h4fe, 12'h600};
  logic [11:0] lo_lvl = 12'h100;
  logic [11:0] hi_lvl = 12'h500;
  logic [3:0]  sel_tab [18] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hb, 4'hc, 4'hd, 4'h5,
                                4'h6, 4'ha, 4'he, 4'hf, 4'h2, 4'hb, 4'hd, 4'h0, 4'h4};
  logic [15:0] exp_q [$];
  logic [9:0]  prev;
  int          num_errors = 0;
  int          comparisons = 0;

  adc_link_if adc_link_if_i ();
  adc_serial_port adc_serial_port_i (.clock_in(clock_in), .nrst_in(nrst_in), .link(adc_link_if_i.device_mp),
    .analog_channel_zero_in(lvl_tab[0]), .analog_channel_one_in(lvl_tab[1]), .analog_channel_two_in(lvl_tab[2]),
    .analog_channel_three_in(lvl_tab[3]), .analog_channel_four_in(lvl_tab[4]), .lower_reference_in(lo_lvl),
    .upper_reference_in(hi_lvl), .result_out(result_out), .result_valid_out(result_valid_out), .busy_out(busy_out));
  adc_host_port adc_host_port_i (.clock_in(clock_in), .nrst_in(nrst_in), .link(adc_link_if_i.host_mp),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_select_in(req_select_in),
    .req_long_in(req_long_in), .req_split_in(req_split_in), .word_valid_out(word_valid_out),
    .word_ready_in(word_ready_in), .word_data_out(word_data_out));
  adc_link_props adc_link_props_i (.clock_in(clock_in), .nrst_in(nrst_in), .sclk(adc_link_if_i.sclk),
    .cs_n(adc_link_if_i.cs_n), .din(adc_link_if_i.din), .dout_drv(adc_link_if_i.dout_drv),
    .dout_oe_n(adc_link_if_i.dout_oe_n), .eoc(adc_link_if_i.eoc));

  // free running system clock
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // code a select should convert to; channels saturate at both references
  function automatic logic [9:0] exp_code(input logic [3:0] s);
    logic [11:0] lvl;
    if (s > `SEL_LAST_CHAN) return (s == `SEL_HALF) ? `CODE_HALF : (s == `SEL_FULL) ? `CODE_FULL : `CODE_ZERO;
    lvl = lvl_tab[s[2:0]];
    if (lvl <= lo_lvl) return 10'h000;
    if (lvl >= hi_lvl || (lvl - lo_lvl) > 12'h3ff) return 10'h3ff;
    return 10'(lvl - lo_lvl);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one request, held until taken, then wait for its conversion to finish
  task automatic xfer(input logic [3:0] sel, input logic lng, input logic spl);
    int n;
    n = 0;
    @(posedge clock_in);
    #2;
    while (req_ready_out !== 1'b1 && n < 3000) begin
      @(posedge clock_in);
      #2;
      n++;
    end
    chk(16'(n >= 3000), 16'h0000);
    req_valid_in = 1'b1;
    req_select_in = sel;
    req_long_in = lng;
    req_split_in = spl;
    @(posedge clock_in);
    #2;
    req_valid_in = 1'b0;
    n = 0;
    while (result_valid_out !== 1'b1 && n < 3000) begin
      @(posedge clock_in);
      #2;
      n++;
    end
    chk(16'(n >= 3000), 16'h0000);
    chk({6'h00, result_out}, {6'h00, exp_code(sel)});
    chk(16'(busy_out), 16'h0000);
  endtask

  // take one returned word off the buffer
  task automatic rd(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clock_in);
    #2;
    while (word_valid_out !== 1'b1 && n < 3000) begin
      @(posedge clock_in);
      #2;
      n++;
    end
    chk(16'(n >= 3000), 16'h0000);
    chk(word_data_out, exp);
    word_ready_in = 1'b1;
    @(posedge clock_in);
    #2;
    word_ready_in = 1'b0;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hang is cut short well beyond the eighteen transfers
  initial begin
    repeat (30000) @(posedge clock_in);
    num_errors++;
    $display("Error at %0t: timeout", $time);
    test_done();
  end

  initial begin
    nrst_in = 1'b0;
    req_valid_in = 1'b0;
    req_select_in = 4'h0;
    req_long_in = 1'b0;
    req_split_in = 1'b0;
    word_ready_in = 1'b0;
    prev = 10'h000;
    repeat (12) @(posedge clock_in);
    #2;
    nrst_in = 1'b1;
    // sixteen transfers mixing short, long and split framing, none read yet
    for (int i = 0; i < 16; i++) begin
      xfer(sel_tab[i], (i % 3) != 0, (i % 3) == 2);
      exp_q.push_back({prev, 6'h00});
      prev = exp_code(sel_tab[i]);
    end
    chk(16'(req_ready_out), 16'h0000);
    $display("test fill done");
    for (int i = 0; i < 16; i++) begin
      rd(exp_q.pop_front());
    end
    chk(16'(word_valid_out), 16'h0000);
    $display("test drain done");
    // read each word right after its transfer
    for (int i = 16; i < 18; i++) begin
      xfer(sel_tab[i], 1'b1, i == 17);
      rd({prev, 6'h00});
      prev = exp_code(sel_tab[i]);
    end
    $display("test stream done");
    test_done();
  end
endmodule
`default_nettype wire
